// ==== common/sys_ctrl_priority_consts.svh ====
// Register map, field layout and fixed-bit constants of the priority slice
// Overview of operation
// R1: Control bit 10 set ignores stack limit faults at negative requested priority.
// R2: Control bit 8 set ignores precise bus faults at negative priority.
// R3: Control bit 4 set enables divide-by-zero usage fault.
// R4: Control bit 3 set traps unaligned word and halfword accesses.
// R5: Control bit 1 clear faults unprivileged trigger writes; set allows pending.
// R6: Control bits 10, 4, 3, 1 keep one copy per Security state.
// R7: Precise bus fault ignore bit is one copy shared by both states.
// R8: Priority registers hold levels 0 to 255 per configurable handler.
// R9: Priority registers accept byte accesses as well as word accesses.
// R10: Only bits 7 down to M stored; low M bits read zero.
// R11: First register: mem 7:0, bus 15:8, usage 23:16, secure 31:24.
// R12: Secure fault priority is read-zero, write-ignored from Non-secure.
// R13: Bus fault priority read-zero from Non-secure when routing bit is 0.
// R14: Usage, memory-management and supervisor-call priorities banked per state.
// R15: Second register: supervisor-call priority 31:24, rest reserved.
// R16: Third register holds pended-service and system tick priorities.
// R17: Third register: tick 31:24, pended-service 23:16, 15:0 reserved.
// R18: Cache/predictor bits read zero; bits 9 and 0 read one.
// R19: Unimplemented low bit count M is a fixed build parameter.
`ifndef SYS_CTRL_PRIORITY_CONSTS_SVH
`define SYS_CTRL_PRIORITY_CONSTS_SVH
`define ADDR_CTRL 4'h0
`define ADDR_PRI1 4'h4
`define ADDR_PRI2 4'h8
`define ADDR_PRI3 4'hC
`define ADDR_EVT_STAT 4'h0
`define BIT_STK_IGN 10
`define BIT_BUS_IGN 8
`define BIT_DIV_TRAP 4
`define BIT_UNAL_TRAP 3
`define BIT_UNPRIV_PEND 1
`define CTRL_FIXED_ONES 32'h0000_0201
`define CTRL_BANKED_MASK 32'h0000_041A
`define PRI_LOW_BITS 4
`define EVT_COUNT 3
`define LANE_MEM 0
`define LANE_BUS 1
`define LANE_USAGE 2
`define LANE_SECURE 3
`define LANE_SVC 3
`define LANE_PEND 2
`define LANE_TICK 3
`define EVT_EN_LANE 2
`define EVT_CLR_LANE 3
`define EVT_EN_LSB 16
`define EVT_CLR_LSB 24
`endif

// ==== common/sys_ctrl_priority_pkg.sv ====
// Types shared by the priority slice
package sys_ctrl_priority_pkg;
  typedef logic [7:0] prio_t;
  typedef logic [31:0] word_t;
  typedef enum logic [1:0] {
    REG_CTRL = 2'b00,
    REG_PRI1 = 2'b01,
    REG_PRI2 = 2'b10,
    REG_PRI3 = 2'b11
  } reg_sel_e;
endpackage

// ==== verilog/sys_ctrl_priority_regs.sv ====
// Control register and system handler priority registers
`timescale 1ns/10ps
`include "sys_ctrl_priority_consts.svh"
module sys_ctrl_priority_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave; address is a byte address
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Security context of the access and routing control
  input wire logic accessSecure,
  input wire logic busFaultNonsecureRoute,
  // Core fault conditions, same clock domain
  input wire logic execSecure,
  input wire logic negativePriority,
  input wire logic stackLimitViolation,
  input wire logic preciseBusError,
  input wire logic divideByZero,
  input wire logic unalignedAccess,
  input wire logic unprivTriggerWrite,
  // Resulting fault and permission strobes
  output logic stackLimitFault,
  output logic preciseBusFault,
  output logic divideZeroFault,
  output logic unalignedFault,
  output logic triggerFault,
  output logic triggerPend,
  // Priority values for the exception logic
  output logic [7:0] memFaultPrioSec,
  output logic [7:0] memFaultPrioNs,
  output logic [7:0] busFaultPrio,
  output logic [7:0] usageFaultPrioSec,
  output logic [7:0] usageFaultPrioNs,
  output logic [7:0] secureFaultPrio,
  output logic [7:0] svCallPrioSec,
  output logic [7:0] svCallPrioNs,
  output logic [7:0] pendedServicePrioSec,
  output logic [7:0] pendedServicePrioNs,
  output logic [7:0] tickTimerPrioSec,
  output logic [7:0] tickTimerPrioNs,
  // Fault event interrupt
  output logic irq
);

  localparam int M = `PRI_LOW_BITS; // see R19
  localparam int EV = `EVT_COUNT;

  // Banked control bits: index 1 secure, 0 non-secure
  logic [31:0] ctrlBank_reg [2]; // see R6
  logic busIgn_reg; // see R7
  // Per-bank priority copies: index 1 secure, 0 non-secure
  logic [7:0] memPrio_reg [2];
  logic [7:0] usagePrio_reg [2];
  logic [7:0] svcPrio_reg [2];
  logic [7:0] pendPrio_reg [2];
  logic [7:0] tickPrio_reg [2];
  logic [7:0] busPrio_reg;
  logic [7:0] securePrio_reg;
  logic ackPending_reg;
  logic [EV-1:0] evtStatus_reg;
  logic [EV-1:0] evtEnable_reg;
  logic [EV-1:0] evtRaise;
  logic [EV-1:0] evtClear;
  logic bank;
  logic wrEn;
  logic [31:0] ctrlView;
  logic [31:0] rdNext;
  sys_ctrl_priority_pkg::reg_sel_e regSel;
  // Control word of the executing state and the control write strobe
  logic [31:0] execCtrl;
  logic ctrlWr;
  // Faults that an ignore bit swallowed, and trigger writes refused for a missing pend permission
  logic stackIgnored;
  logic busIgnored;
  logic triggerRefused;

  // Keep implemented bits only, low bits forced zero
  function automatic logic [7:0] trimPrio(input logic [7:0] v);
    trimPrio = {v[7:M], {M{1'b0}}}; // see R10
  endfunction

  // Byte merge for one priority field in a given lane
  function automatic logic [7:0] mergeLane(input logic [7:0] old,
      input logic [31:0] wd, input logic [3:0] be, input int lane);
    mergeLane = be[lane] ? trimPrio(wd[lane*8 +: 8]) : old; // see R9
  endfunction

  assign bank = accessSecure;
  // One wait cycle then acknowledge; registered answer
  assign wrEn = write & ackPending_reg;
  assign regSel = sys_ctrl_priority_pkg::reg_sel_e'(address[3:2]);
  assign ctrlWr = wrEn && regSel == sys_ctrl_priority_pkg::REG_CTRL;
  // Fault paths follow the executing state, not the accessing one
  assign execCtrl = ctrlBank_reg[execSecure];

  // Two-phase handshake: request seen, then acknowledged
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ackPending_reg <= 1'b0;
    end else if (ackPending_reg) begin
      ackPending_reg <= 1'b0;
    end else begin
      ackPending_reg <= read | write;
    end
  end

  // Low exactly in the cycle after a request is first seen
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & ~ackPending_reg);
    end
  end

  // Control register writes: banked bits into the accessing bank
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrlBank_reg[0] <= 32'h0000_0000;
      ctrlBank_reg[1] <= 32'h0000_0000;
      busIgn_reg <= 1'b0;
    end else if (ctrlWr) begin
      ctrlBank_reg[bank] <= writedata & `CTRL_BANKED_MASK; // see R6
      if (bank) begin
        busIgn_reg <= writedata[`BIT_BUS_IGN]; // see R7
      end
    end
  end

  // Priority registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int b = 0; b < 2; b++) begin
        memPrio_reg[b] <= 8'h00;
        usagePrio_reg[b] <= 8'h00;
        svcPrio_reg[b] <= 8'h00;
        pendPrio_reg[b] <= 8'h00;
        tickPrio_reg[b] <= 8'h00;
      end
      busPrio_reg <= 8'h00;
      securePrio_reg <= 8'h00;
    end else if (wrEn) begin // see R8
      unique case (regSel)
        sys_ctrl_priority_pkg::REG_PRI1: begin // see R11
          memPrio_reg[bank] <= mergeLane(memPrio_reg[bank], writedata,
            byteenable, `LANE_MEM); // see R14
          usagePrio_reg[bank] <= mergeLane(usagePrio_reg[bank],
            writedata, byteenable, `LANE_USAGE);
          if (bank || busFaultNonsecureRoute) begin // see R13
            busPrio_reg <= mergeLane(busPrio_reg, writedata, byteenable,
              `LANE_BUS);
          end
          if (bank) begin // see R12
            securePrio_reg <= mergeLane(securePrio_reg, writedata,
              byteenable, `LANE_SECURE);
          end
        end
        sys_ctrl_priority_pkg::REG_PRI2: begin // see R15
          svcPrio_reg[bank] <= mergeLane(svcPrio_reg[bank], writedata,
            byteenable, `LANE_SVC);
        end
        sys_ctrl_priority_pkg::REG_PRI3: begin // see R16 R17
          pendPrio_reg[bank] <= mergeLane(pendPrio_reg[bank], writedata,
            byteenable, `LANE_PEND);
          tickPrio_reg[bank] <= mergeLane(tickPrio_reg[bank], writedata,
            byteenable, `LANE_TICK);
        end
        sys_ctrl_priority_pkg::REG_CTRL: begin
        end
      endcase
    end
  end

  // Control view: cache bits zero, fixed ones in bits 9 and 0
  always_comb begin
    ctrlView = ctrlBank_reg[bank] | `CTRL_FIXED_ONES; // see R18
    ctrlView[`BIT_BUS_IGN] = busIgn_reg;
  end

  // Read mux: fields hidden from the accessing state read zero
  always_comb begin
    rdNext = 32'h0000_0000;
    unique case (regSel)
      sys_ctrl_priority_pkg::REG_CTRL: rdNext = ctrlView;
      sys_ctrl_priority_pkg::REG_PRI1: begin
        rdNext[7:0] = memPrio_reg[bank];
        rdNext[15:8] = (bank || busFaultNonsecureRoute) ?
          busPrio_reg : 8'h00; // see R13
        rdNext[23:16] = usagePrio_reg[bank];
        rdNext[31:24] = bank ? securePrio_reg : 8'h00; // see R12
      end
      sys_ctrl_priority_pkg::REG_PRI2: rdNext[31:24] = svcPrio_reg[bank];
      sys_ctrl_priority_pkg::REG_PRI3: begin
        rdNext[23:16] = pendPrio_reg[bank];
        rdNext[31:24] = tickPrio_reg[bank];
      end
    endcase
  end

  // Captured while waiting so the data stands at the accepting edge
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (read & ~ackPending_reg) begin
      readdata <= rdNext;
    end
  end

  // Fault qualification from the executing state's bank; the bus fault uses the shared ignore bit
  // Stack limit fault, dropped at negative priority when ignored
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      stackLimitFault <= 1'b0;
    end else begin
      stackLimitFault <= stackLimitViolation &
        ~(negativePriority & execCtrl[`BIT_STK_IGN]); // see R1
    end
  end

  // Precise bus fault; the ignore bit is shared by both states
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      preciseBusFault <= 1'b0;
    end else begin
      preciseBusFault <= preciseBusError &
        ~(negativePriority & busIgn_reg); // see R2
    end
  end

  // Divide-by-zero usage fault
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      divideZeroFault <= 1'b0;
    end else begin
      divideZeroFault <= divideByZero & execCtrl[`BIT_DIV_TRAP]; // see R3
    end
  end

  // Unaligned access trap
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      unalignedFault <= 1'b0;
    end else begin
      unalignedFault <= unalignedAccess & execCtrl[`BIT_UNAL_TRAP]; // see R4
    end
  end

  // Unprivileged trigger write: refused or allowed to pend, never both
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      triggerFault <= 1'b0;
      triggerPend <= 1'b0;
    end else begin
      triggerFault <= triggerRefused; // see R5
      triggerPend <= unprivTriggerWrite &
        execCtrl[`BIT_UNPRIV_PEND]; // see R5
    end
  end

  // Priorities out, registered copies already trimmed on write.
  // The extra cycle keeps the exception logic off the bus decode path.
  // Memory-management fault priority, both banks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      memFaultPrioSec <= 8'h00;
      memFaultPrioNs <= 8'h00;
    end else begin
      memFaultPrioSec <= memPrio_reg[1];
      memFaultPrioNs <= memPrio_reg[0];
    end
  end

  // Usage fault priority, both banks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      usageFaultPrioSec <= 8'h00;
      usageFaultPrioNs <= 8'h00;
    end else begin
      usageFaultPrioSec <= usagePrio_reg[1];
      usageFaultPrioNs <= usagePrio_reg[0];
    end
  end

  // Bus fault priority, one shared copy
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      busFaultPrio <= 8'h00;
    end else begin
      busFaultPrio <= busPrio_reg;
    end
  end

  // Secure fault priority, Secure side only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      secureFaultPrio <= 8'h00;
    end else begin
      secureFaultPrio <= securePrio_reg;
    end
  end

  // Supervisor call priority, both banks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      svCallPrioSec <= 8'h00;
      svCallPrioNs <= 8'h00;
    end else begin
      svCallPrioSec <= svcPrio_reg[1];
      svCallPrioNs <= svcPrio_reg[0];
    end
  end

  // Pended service priority, both banks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pendedServicePrioSec <= 8'h00;
      pendedServicePrioNs <= 8'h00;
    end else begin
      pendedServicePrioSec <= pendPrio_reg[1];
      pendedServicePrioNs <= pendPrio_reg[0];
    end
  end

  // Tick timer priority, both banks
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tickTimerPrioSec <= 8'h00;
      tickTimerPrioNs <= 8'h00;
    end else begin
      tickTimerPrioSec <= tickPrio_reg[1];
      tickTimerPrioNs <= tickPrio_reg[0];
    end
  end

  // Sticky events: ignored stack fault, ignored bus fault, trigger fault.
  // Enable and clear ride on the control word's upper reserved lanes,
  // which software otherwise sees as zero.
  assign stackIgnored = stackLimitViolation & negativePriority &
    execCtrl[`BIT_STK_IGN];
  assign busIgnored = preciseBusError & negativePriority & busIgn_reg;
  assign triggerRefused = unprivTriggerWrite & ~execCtrl[`BIT_UNPRIV_PEND];
  assign evtRaise = {triggerRefused, busIgnored, stackIgnored};
  assign evtClear = (ctrlWr && byteenable[`EVT_CLR_LANE] && bank) ?
    writedata[`EVT_CLR_LSB +: EV] : '0;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evtStatus_reg <= '0;
    end else begin
      // Raise wins over a clear in the same cycle
      evtStatus_reg <= (evtStatus_reg & ~evtClear) | evtRaise;
    end
  end

  // Enable writes come from the Secure state only
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      evtEnable_reg <= '0;
    end else if (ctrlWr && byteenable[`EVT_EN_LANE] && bank) begin
      evtEnable_reg <= writedata[`EVT_EN_LSB +: EV];
    end
  end

  // Next status feeds irq so it rises together with the fault strobes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((evtStatus_reg & ~evtClear) | evtRaise) & evtEnable_reg);
    end
  end

endmodule // sys_ctrl_priority_regs

// ==== sim/sys_ctrl_priority_assertions.sv ====
// Port-level assertions for the control and priority register slice
`timescale 1ns/10ps
module sys_ctrl_priority_assertions (
  // Clock, reset and bus handshake
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Fault causes
  input wire logic negativePriority,
  input wire logic stackLimitViolation,
  input wire logic preciseBusError,
  input wire logic divideByZero,
  input wire logic unalignedAccess,
  input wire logic unprivTriggerWrite,
  // Fault results
  input wire logic stackLimitFault,
  input wire logic preciseBusFault,
  input wire logic divideZeroFault,
  input wire logic unalignedFault,
  input wire logic triggerFault,
  input wire logic triggerPend,
  // Priority outputs and interrupt
  input wire logic [7:0] memFaultPrioSec,
  input wire logic [7:0] svCallPrioNs,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  bus_answer_a: assert property ($rose(read || write) |=>
    !waitrequest ##1 waitrequest) else $error("bus answer not one cycle");
  stk_nonneg_a: assert property (stackLimitViolation && !negativePriority
    |=> stackLimitFault) else $error("stack fault lost");
  stk_cause_a: assert property (stackLimitFault |->
    $past(stackLimitViolation)) else $error("stack fault without cause");
  bus_nonneg_a: assert property (preciseBusError && !negativePriority
    |=> preciseBusFault) else $error("bus fault lost");
  bus_cause_a: assert property (preciseBusFault |->
    $past(preciseBusError)) else $error("bus fault without cause");
  div_cause_a: assert property (divideZeroFault |->
    $past(divideByZero)) else $error("divide fault without cause");
  unal_cause_a: assert property (unalignedFault |->
    $past(unalignedAccess)) else $error("unaligned fault without cause");
  trig_split_a: assert property (unprivTriggerWrite |=>
    triggerFault != triggerPend) else $error("trigger not fault xor pend");
  trig_cause_a: assert property (triggerFault || triggerPend |->
    $past(unprivTriggerWrite)) else $error("trigger result without cause");
  prio_low_a: assert property (memFaultPrioSec[3:0] == 4'h0 &&
    svCallPrioNs[3:0] == 4'h0) else $error("low priority bits not zero");
  cover property (stackLimitViolation && negativePriority ##1 !stackLimitFault);
  cover property ($rose(irq));
  cover property (triggerPend);
endmodule // sys_ctrl_priority_assertions
bind sys_ctrl_priority_regs sys_ctrl_priority_assertions chk (.*);

// ==== sim/tb_sys_ctrl_priority_regs.sv ====
// Self-checking bench for the control and priority register slice
`timescale 1ns/10ps
module tb_sys_ctrl_priority_regs;
  logic ref_clk = 0, rst_n = 0, read = 0, write = 0, accessSecure = 0;
  logic busFaultNonsecureRoute = 0, execSecure = 0, negativePriority = 0;
  logic stackLimitViolation = 0, preciseBusError = 0, divideByZero = 0;
  logic unalignedAccess = 0, unprivTriggerWrite = 0;
  logic [3:0] address = 4'h0, byteenable = 4'h0;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic waitrequest, stackLimitFault, preciseBusFault, divideZeroFault;
  logic unalignedFault, triggerFault, triggerPend, irq, shBus = 0, s;
  logic [7:0] memFaultPrioSec, memFaultPrioNs, busFaultPrio, secureFaultPrio;
  logic [7:0] usageFaultPrioSec, usageFaultPrioNs, svCallPrioSec, svCallPrioNs;
  logic [7:0] pendedServicePrioSec, pendedServicePrioNs;
  logic [7:0] tickTimerPrioSec, tickTimerPrioNs;
  logic [7:0] pri [2][7];
  logic [31:0] ctl [2], d, e;
  logic [2:0] ev = 3'h0;
  int fails = 0, num_checks = 0;
  sys_ctrl_priority_regs uut (.*);
  initial forever #5 ref_clk = ~ref_clk;
  initial begin
    #400000;
    fails++;
    results();
  end
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Field index per byte lane, -1 for reserved lanes; bus and secure shared
  function automatic int fld(input logic [3:0] a, input int l);
    if (a == 4'h4) return l;
    if (a == 4'h8) return l == 3 ? 4 : -1;
    return l >= 2 ? l + 3 : -1;
  endfunction
  function automatic bit okf(input int f, input logic sc);
    return f >= 0 && (f == 3 ? sc : (f == 1 ? sc || busFaultNonsecureRoute : 1));
  endfunction
  function automatic logic [31:0] expv(input logic [3:0] a, input logic sc);
    logic [31:0] r;
    int f;
    if (a == 4'h0) return 32'h201 | ctl[sc] & 32'h41A | {shBus, 8'h0};
    for (int l = 0; l < 4; l++) begin
      f = fld(a, l);
      r[8*l+:8] = okf(f, sc) ? pri[(f == 1 || f == 3) ? 1 : sc][f] : 8'h0;
    end
    return r;
  endfunction
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] v,
                     input logic [3:0] be, input logic sc);
    int n, f;
    n = 0;
    @(posedge ref_clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= v;
    byteenable <= be;
    accessSecure <= sc;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'h1, 32'h0);
    rd = readdata;
    read <= 0;
    write <= 0;
    if (w && a == 4'h0) ctl[sc] = v;
    if (w && a == 4'h0 && sc) shBus = v[8];
    for (int l = 0; l < 4; l++) begin
      f = fld(a, l);
      if (w && a != 4'h0 && be[l] && okf(f, sc))
        pri[(f == 1 || f == 3) ? 1 : sc][f] = v[8*l+:8] & 8'hF0;
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic sc);
    acc(0, a, 32'h0, 4'hF, sc);
    chk(rd, expv(a, sc));
  endtask
  initial begin
    void'($urandom(32'h3e59));
    pri = '{default: '{default: 8'h0}};
    ctl = '{default: 32'h0};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++) rchk(4 * (i % 4), i / 4);
    // Corner: Non-secure then Secure all-ones writes with routing off, reserved lanes
    acc(1, 4'h4, 32'hFFFF_FFFF, 4'hF, 0);
    acc(1, 4'h8, 32'hFFFF_FFFF, 4'hF, 1);
    for (int i = 0; i < 8; i++) begin
      d = $urandom & 32'hFFFF;
      acc(1, 4'h0, i == 0 ? 32'hFFFF : d, 4'hF, i[0]);
      rchk(4'h0, 0);
      rchk(4'h0, 1);
    end
    for (int i = 0; i < 60; i++) begin
      busFaultNonsecureRoute <= $urandom;
      s = $urandom;
      acc(1, 4 * $urandom_range(3, 1), $urandom, $urandom, s);
      rchk(4 * $urandom_range(3, 1), $urandom);
      chk({memFaultPrioSec, memFaultPrioNs, busFaultPrio, usageFaultPrioSec},
          {pri[1][0], pri[0][0], pri[1][1], pri[1][2]});
      chk({usageFaultPrioNs, secureFaultPrio, svCallPrioSec, svCallPrioNs},
          {pri[0][2], pri[1][3], pri[1][4], pri[0][4]});
      chk({pendedServicePrioSec, pendedServicePrioNs, tickTimerPrioSec,
           tickTimerPrioNs}, {pri[1][5], pri[0][5], pri[1][6],
           pri[0][6]});
    end
    for (int i = 0; i < 80; i++) begin
      {execSecure, negativePriority, stackLimitViolation, preciseBusError,
       divideByZero, unalignedAccess, unprivTriggerWrite} <= $urandom;
      repeat (2) @(posedge ref_clk);
      d = ctl[execSecure];
      ev |= {unprivTriggerWrite & !d[1], preciseBusError & negativePriority
             & shBus, stackLimitViolation & negativePriority & d[10]};
      chk({stackLimitFault, preciseBusFault, divideZeroFault, unalignedFault,
           triggerFault, triggerPend, irq},
          {stackLimitViolation & !(negativePriority & d[10]),
           preciseBusError & !(negativePriority & shBus),
           divideByZero & d[4], unalignedAccess & d[3],
           unprivTriggerWrite & !d[1], unprivTriggerWrite & d[1],
           1'b0});
    end
    {stackLimitViolation, preciseBusError, divideByZero, unalignedAccess,
     unprivTriggerWrite} <= 5'h0;
    acc(1, 4'h0, 32'h0007_0000, 4'hF, 1);
    repeat (3) @(posedge ref_clk);
    chk(irq, |ev);
    // Event, mask, unmask while still sticky, then clear
    acc(1, 4'h0, 32'h0707_0500, 4'hF, 1);
    {execSecure, negativePriority, stackLimitViolation} <= 3'h7;
    @(posedge ref_clk);
    stackLimitViolation <= 0;
    for (int i = 0; i < 4; i++) begin
      e = i == 1 ? 32'h0006_0500 : 32'h0007_0500;
      if (i > 0) acc(1, 4'h0, i == 3 ? 32'h0707_0500 : e, 4'hF, 1);
      repeat (3) @(posedge ref_clk);
      chk(irq, i == 0 || i == 2);
    end
    results();
  end
endmodule // tb_sys_ctrl_priority_regs
